// ==== hdl/cgi_slave_port.sv ====
// Two-wire slave port: address match, register pointer, byte writes
// and reads into a 256-byte configuration store, SDA stall timeout.
// Assumes SCL and SDA arrive asynchronously from open-drain wires.
`timescale 1ns/1ns
`include "cgi_params.svh"
module cgi_slave_port #(
  parameter int TimeoutCyc = `CGI_TIMEOUT_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic sclPin,
  input wire cgi_pkg::cgi_sda_t sdaPin,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic addrSelPin,
  output logic lowVoltMode,
  output logic wrStrobe,
  output logic [7:0] wrAddr,
  output logic [7:0] wrData
);
  cgi_pkg::cgi_state_t st_r;
  cgi_pkg::cgi_state_t st_nxt;
  logic [7:0] mem [0:255];
  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;
  logic sclS;
  logic sdaS;
  logic selS;
  logic addrMatch;
  logic wrEn_nxt;
  logic wrEn_r;
  logic [7:0] wa_r;
  logic [7:0] wd_r;

  // oversampled bus edges
  // Edges from the second synchroniser stage only
  assign sclS = st_r.sclSync[1];
  assign sdaS = st_r.sdaSync[1];
  assign selS = st_r.selSync[1];
  assign sclRise = sclS & ~st_r.sclPrev;
  assign sclFall = ~sclS & st_r.sclPrev;
  assign startCond = sclS & st_r.sclPrev & st_r.sdaPrev & ~sdaS;
  assign stopCond = sclS & st_r.sclPrev & ~st_r.sdaPrev & sdaS;

  // 70h or 71h by select pin
  // Whole byte in: address in bits 7..1, direction in bit 0
  assign addrMatch = (st_r.shift[7:2] == `CGI_ADDR_HI) &&
                     (st_r.shift[1] == selS);

  // only the data line is ever driven
  assign sdaOut = 1'b0;
  assign sdaOe = st_r.sdaLow;
  assign lowVoltMode = st_r.lowVolt;
  assign wrStrobe = wrEn_r;
  assign wrAddr = wa_r;
  assign wrData = wd_r;

  // Protocol state machine, one step per clk_sys cycle; bits move on SCL edges
  always_comb begin
    st_nxt = st_r;
    wrEn_nxt = 1'b0;
    st_nxt.sclSync = {st_r.sclSync[0], sclPin};
    st_nxt.sdaSync = {st_r.sdaSync[0], sdaPin.sdaIn};
    st_nxt.selSync = {st_r.selSync[0], addrSelPin};
    st_nxt.sclPrev = sclS;
    st_nxt.sdaPrev = sdaS;
    // count while data line held low
    if (sdaS) begin
      st_nxt.toCnt = 32'h0;
    end else if (st_r.toCnt != 32'hffffffff) begin
      st_nxt.toCnt = st_r.toCnt + 32'h1;
    end
    if (startCond) begin
      st_nxt.phase = cgi_pkg::PH_ADDR;
      st_nxt.bitCnt = 4'h0;
      st_nxt.sdaLow = 1'b0;
    end else if (stopCond) begin
      st_nxt.phase = cgi_pkg::PH_IDLE;
      st_nxt.sdaLow = 1'b0;
    end else if (st_r.toCnt >= 32'(TimeoutCyc)) begin
      st_nxt.phase = cgi_pkg::PH_IDLE;
      st_nxt.sdaLow = 1'b0;
      st_nxt.toCnt = 32'h0;
    end else begin
      unique case (st_r.phase)
        cgi_pkg::PH_IDLE: begin
        end
        cgi_pkg::PH_ADDR, cgi_pkg::PH_REG, cgi_pkg::PH_WDATA: begin
          if (sclRise) begin
            st_nxt.shift = {st_r.shift[6:0], sdaS};
            st_nxt.bitCnt = st_r.bitCnt + 4'h1;
          end
          if (sclFall && st_r.bitCnt == 4'h8) begin
            st_nxt.bitCnt = 4'h0;
            st_nxt.phase = cgi_pkg::PH_ACK;
            st_nxt.sdaLow = 1'b1;
            if (st_r.phase == cgi_pkg::PH_ADDR) begin
              st_nxt.readDir = st_r.shift[0];
              if (!addrMatch) begin
                st_nxt.phase = cgi_pkg::PH_IDLE;
                st_nxt.sdaLow = 1'b0;
              end
              st_nxt.nextPh = st_r.shift[0] ? cgi_pkg::PH_RDATA
                                            : cgi_pkg::PH_REG;
            end else if (st_r.phase == cgi_pkg::PH_REG) begin
              st_nxt.regAddr = st_r.shift;
              st_nxt.nextPh = cgi_pkg::PH_WDATA;
            end else begin
              // data byte to pointer, then advance
              wrEn_nxt = 1'b1;
              if (st_r.regAddr == `CGI_LOWV_REG) begin
                st_nxt.lowVolt = st_r.shift[`CGI_LOWV_BIT];
              end
              st_nxt.regAddr = st_r.regAddr + 8'h1;
              st_nxt.nextPh = cgi_pkg::PH_WDATA;
            end
          end
        end
        cgi_pkg::PH_ACK: begin
          // Release after ack clock; preload read byte
          if (sclFall) begin
            st_nxt.phase = st_r.nextPh;
            st_nxt.sdaLow = 1'b0;
            if (st_r.nextPh == cgi_pkg::PH_RDATA) begin
              st_nxt.shift = mem[st_r.regAddr];
              st_nxt.sdaLow = ~mem[st_r.regAddr][7];
              st_nxt.bitCnt = 4'h1;
            end
          end
        end
        cgi_pkg::PH_RDATA: begin
          // drive MSB first, change on falling SCL
          if (sclFall) begin
            if (st_r.bitCnt == 4'h8) begin
              st_nxt.phase = cgi_pkg::PH_RACK;
              st_nxt.sdaLow = 1'b0;
              st_nxt.regAddr = st_r.regAddr + 8'h1;
            end else begin
              st_nxt.shift = {st_r.shift[6:0], 1'b0};
              st_nxt.sdaLow = ~st_r.shift[6];
              st_nxt.bitCnt = st_r.bitCnt + 4'h1;
            end
          end
        end
        cgi_pkg::PH_RACK: begin
          // Master nack ends the read; ack preloads the next byte
          // at once, else its top bit would miss its clock
          if (sclRise) begin
            st_nxt.nextPh = sdaS ? cgi_pkg::PH_IDLE : cgi_pkg::PH_RDATA;
          end
          if (sclFall) begin
            st_nxt.phase = st_r.nextPh;
            if (st_r.nextPh == cgi_pkg::PH_RDATA) begin
              st_nxt.shift = mem[st_r.regAddr];
              st_nxt.sdaLow = ~mem[st_r.regAddr][7];
              st_nxt.bitCnt = 4'h1;
            end
          end
        end
        default: begin
          st_nxt.phase = cgi_pkg::PH_IDLE;
          st_nxt.sdaLow = 1'b0;
        end
      endcase
    end
  end

  // State register; reset clears the low-voltage bit, not the store
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_r <= '0;
      st_r.sclSync <= 2'b11;
      st_r.sdaSync <= 2'b11;
      st_r.sclPrev <= 1'b1;
      st_r.sdaPrev <= 1'b1;
      wrEn_r <= 1'b0;
      wa_r <= 8'h00;
      wd_r <= 8'h00;
    end else begin
      st_r <= st_nxt;
      wrEn_r <= wrEn_nxt;
      if (wrEn_nxt) begin
        wa_r <= st_r.regAddr;
        wd_r <= st_r.shift;
      end
    end
  end

  // Store without reset; rewritten bytes read back
  always_ff @(posedge clk_sys) begin
    if (wrEn_nxt) begin
      mem[st_r.regAddr] <= st_r.shift;
    end
  end

  // Never drives high; only pulls data low
  property p_noDriveHigh;
    @(posedge clk_sys) disable iff (rst) sdaOe |-> !sdaOut;
  endproperty
  a_noDriveHigh: assert property (p_noDriveHigh)
    else $error("data line driven high");

  property p_addrAck;
    @(posedge clk_sys) disable iff (rst)
      (st_r.phase == cgi_pkg::PH_ADDR && sclFall && st_r.bitCnt == 4'h8
       && addrMatch && st_r.toCnt < 32'(TimeoutCyc))
      |=> (sdaOe && st_r.phase == cgi_pkg::PH_ACK);
  endproperty
  a_addrAck: assert property (p_addrAck)
    else $error("matching address not acknowledged");

  property p_addrNack;
    @(posedge clk_sys) disable iff (rst)
      (st_r.phase == cgi_pkg::PH_ADDR && sclFall && st_r.bitCnt == 4'h8
       && !startCond && !stopCond
       && st_r.shift[7:1] != {`CGI_ADDR_HI, selS})
      |=> (!sdaOe && st_r.phase == cgi_pkg::PH_IDLE);
  endproperty
  a_addrNack: assert property (p_addrNack)
    else $error("foreign address acknowledged");

  sequence s_stuckLow;
    st_r.toCnt >= 32'(TimeoutCyc) && !startCond && !stopCond;
  endsequence
  property p_timeout;
    @(posedge clk_sys) disable iff (rst)
      s_stuckLow |=> (!sdaOe && st_r.phase == cgi_pkg::PH_IDLE);
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("stall not abandoned");

  property p_wrLowV;
    @(posedge clk_sys) disable iff (rst)
      (wrEn_nxt && st_r.regAddr == 8'h1b) |=>
        (lowVoltMode == $past(st_r.shift[7]) && wrStrobe);
  endproperty
  a_wrLowV: assert property (p_wrLowV)
    else $error("low-voltage bit not taken");

  property p_msbFirst;
    @(posedge clk_sys) disable iff (rst)
      (st_r.phase == cgi_pkg::PH_RDATA && sclFall && st_r.bitCnt != 4'h8
       && !startCond && !stopCond && st_r.toCnt < 32'(TimeoutCyc))
      |=> (sdaOe == !$past(st_r.shift[6]));
  endproperty
  a_msbFirst: assert property (p_msbFirst)
    else $error("read bit order wrong");

  property p_ptrAdvance;
    @(posedge clk_sys) disable iff (rst)
      wrEn_nxt |=> (st_r.regAddr == $past(st_r.regAddr) + 8'h1);
  endproperty
  a_ptrAdvance: assert property (p_ptrAdvance)
    else $error("pointer did not advance");

  property p_stopRel;
    @(posedge clk_sys) disable iff (rst)
      stopCond |=> (!sdaOe && st_r.phase == cgi_pkg::PH_IDLE);
  endproperty
  a_stopRel: assert property (p_stopRel)
    else $error("stop did not release bus");
endmodule // cgi_slave_port

// ==== hdl/cgi_params.svh ====
// Constants of the two-wire slave port of the clock generator.
// Assumes a 20 MHz system clock; included by the package and the port.
`ifndef CGI_PARAMS_SVH
`define CGI_PARAMS_SVH
`define CGI_ADDR_HI 6'h38
`define CGI_CLK_MHZ 20
`define CGI_TIMEOUT_US 25000
`define CGI_TIMEOUT_CYC (`CGI_TIMEOUT_US * `CGI_CLK_MHZ)
`define CGI_LOWV_REG 8'h1b
`define CGI_LOWV_BIT 7
`define CGI_REG_RST 8'h00
`endif

// ==== hdl/cgi_pkg.sv ====
// Types of the two-wire slave port: phase enum, pin group, state struct.
// Assumes cgi_params.svh is on the include path.
`include "cgi_params.svh"
package cgi_pkg;
  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_ADDR = 3'b001,
    PH_REG = 3'b010,
    PH_WDATA = 3'b011,
    PH_RDATA = 3'b100,
    PH_ACK = 3'b101,
    PH_RACK = 3'b110
  } cgi_phase_t;
  typedef struct packed {
    logic sdaIn;
    logic sdaOut;
    logic sdaOe;
  } cgi_sda_t;
  typedef struct packed {
    cgi_phase_t phase;
    cgi_phase_t nextPh;
    logic [7:0] shift;
    logic [3:0] bitCnt;
    logic readDir;
    logic [7:0] regAddr;
    logic sdaLow;
    logic lowVolt;
    logic [31:0] toCnt;
    logic [1:0] sclSync;
    logic [1:0] sdaSync;
    logic [1:0] selSync;
    logic sclPrev;
    logic sdaPrev;
  } cgi_state_t;
endpackage

// ==== sim/cgi_master_model.sv ====
// Bus master model: drives the clock line, pulls the data line low.
// Assumes a 20 MHz clk_sys; one bit takes 8 cycles, 400 ns.
`timescale 1ns/1ns
module cgi_master_model (
  input wire logic clk_sys,
  input wire logic sdaWire,
  output logic sclLine,
  output logic sdaPull
);
  // Idle: clock stands high, data left to the pull-up
  initial begin
    sclLine = 1'b1;
    sdaPull = 1'b0;
  end
  // Steps land just after an edge, never on it
  task automatic tk(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask
  task automatic start();
    sdaPull = 1'b0;
    tk(4);
    sclLine = 1'b1;
    tk(2);
    sdaPull = 1'b1;
    tk(2);
    sclLine = 1'b0;
    tk(1);
  endtask
  task automatic stop();
    sdaPull = 1'b1;
    tk(4);
    sclLine = 1'b1;
    tk(2);
    sdaPull = 1'b0;
    tk(4);
  endtask
  // 400 ns bit
  // Data moves one cycle after the fall so no false start is seen
  task automatic bitx(input logic b, output logic s);
    sdaPull = ~b;
    tk(3);
    sclLine = 1'b1;
    tk(2);
    s = sdaWire;
    tk(2);
    sclLine = 1'b0;
    tk(1);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bitx(d[i], s);
    bitx(1'b1, s);
    ack = ~s;
  endtask
  // byte in; last byte gets no acknowledge
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(last, s);
  endtask
  // Clock held low, data released: a stalled transfer
  task automatic idle(input int n);
    sdaPull = 1'b0;
    tk(n);
  endtask
endmodule // cgi_master_model

// ==== sim/tb_clockgen_i2c_slave_port.sv ====
// Self-checking bench of the two-wire slave port against a master model.
// Assumes the design files under hdl/ and a short stall timeout.
`timescale 1ns/1ns
module tb_clockgen_i2c_slave_port;
  localparam int ToCyc = 2000;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic addrSel = 1'b0;
  logic sclLine, sdaPull, sdaWire, sdaOut, sdaOe, lowVolt, wrStrobe, ack;
  logic [7:0] wrAddr, wrData, wA, wD, rd;
  logic [7:0] nW = 8'h00;
  cgi_pkg::cgi_sda_t sdaBus;
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;
  // Open-drain wire with pull-up: low if either side pulls
  assign sdaWire = ~(sdaPull | sdaOe);
  assign sdaBus = {sdaWire, sdaOut, sdaOe};
  always #25 clk_sys = ~clk_sys;
  cgi_slave_port #(.TimeoutCyc(ToCyc)) i_cgi_slave_port (
    .clk_sys(clk_sys), .rst(rst), .sclPin(sclLine), .sdaPin(sdaBus),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .addrSelPin(addrSel),
    .lowVoltMode(lowVolt), .wrStrobe(wrStrobe), .wrAddr(wrAddr),
    .wrData(wrData));
  cgi_master_model mst (
    .clk_sys(clk_sys), .sdaWire(sdaWire), .sclLine(sclLine),
    .sdaPull(sdaPull));
  // Byte log; counting high cycles also catches a stretched strobe
  always @(posedge clk_sys) begin
    cyc++;
    if (wrStrobe === 1'b1) begin
      nW <= nW + 8'h01;
      wA <= wrAddr;
      wD <= wrData;
    end
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_sim();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Both select levels against matching and foreign addresses
  task automatic t_addr();
    logic [7:0] tab [4] = '{8'he0, 8'he2, 8'h60, 8'hf0};
    for (int s = 0; s < 2; s++) begin
      addrSel = s[0];
      for (int k = 0; k < 4; k++) begin
        mst.start();
        mst.wbyte(tab[k], ack);
        mst.stop();
        chk("addr ack", {7'h0, tab[k][7:1] == {6'b111000, s[0]}},
            {7'h0, ack});
      end
    end
    addrSel = 1'b0;
  endtask
  // Two back-to-back bytes from register 27 on
  task automatic t_write();
    logic [7:0] n0;
    n0 = nW;
    mst.start();
    mst.wbyte(8'he0, ack);
    mst.wbyte(8'h1b, ack);
    chk("reg ack", 8'h01, {7'h0, ack});
    mst.wbyte(8'h80, ack);
    mst.wbyte(8'h5a, ack);
    mst.stop();
    chk("strobes", n0 + 8'h02, nW);
    chk("wr addr", 8'h1c, wA);
    chk("wr data", 8'h5a, wD);
    chk("low volt", 8'h01, {7'h0, lowVolt});
  endtask
  // Pointer write, repeated start, two reads, then clear bit 7
  task automatic t_read();
    mst.start();
    mst.wbyte(8'he0, ack);
    mst.wbyte(8'h1b, ack);
    mst.start();
    mst.wbyte(8'he1, ack);
    chk("rd ack", 8'h01, {7'h0, ack});
    mst.rbyte(1'b0, rd);
    chk("rd byte0", 8'h80, rd);
    mst.rbyte(1'b1, rd);
    chk("rd byte1", 8'h5a, rd);
    mst.start();
    mst.wbyte(8'he0, ack);
    mst.wbyte(8'h1b, ack);
    mst.wbyte(8'h00, ack);
    mst.stop();
    chk("low volt", 8'h00, {7'h0, lowVolt});
  endtask
  // Master stalls in the acknowledge slot with the clock low
  task automatic t_stall();
    logic [7:0] a = 8'he0;
    logic s;
    mst.start();
    for (int i = 7; i >= 0; i--) mst.bitx(a[i], s);
    mst.idle(8);
    chk("stall oe", 8'h01, {7'h0, sdaOe});
    chk("sda out", 8'h00, {7'h0, sdaOut});
    mst.idle(ToCyc + 100);
    chk("timeout oe", 8'h00, {7'h0, sdaOe});
    mst.stop();
  endtask
  // Mid-run reset clears the low-voltage bit and frees the line
  task automatic t_reset();
    rst = 1'b1;
    repeat (2) @(posedge clk_sys);
    #2;
    chk("rst low volt", 8'h00, {7'h0, lowVolt});
    chk("rst oe", 8'h00, {7'h0, sdaOe});
    rst = 1'b0;
    repeat (4) @(posedge clk_sys);
    #2;
  endtask
  initial begin
    repeat (16) @(posedge clk_sys);
    #2 rst = 1'b0;
    repeat (4) @(posedge clk_sys);
    #2;
    t_addr();
    t_write();
    t_read();
    t_stall();
    t_write();
    t_reset();
    t_write();
    end_sim();
  end
endmodule // tb_clockgen_i2c_slave_port
